// *** verif/sstk_core_model.sv ***
// Behavioural core side: pointer update events and entry frames
`timescale 1ns/1ns
module sstk_core_model
  import sstk_pkg::*;
(
  input wire logic clk_in,
  output sstk_evt_t evt_out,
  output sstk_entry_t entry_out
);
  // Quiet until asked
  initial begin
    evt_out = '0;
    entry_out = '0;
  end
  // One-cycle update pulse; kind 0 push, 1 pop, 2 sub, 3 add
  task automatic step(input logic [1:0] k, input logic [15:0] sp, input logic [15:0] amt);
    @(posedge clk_in);
    evt_out <= {k == 2'h0, k == 2'h1, k == 2'h2, k == 2'h3, k[0] ? sp + amt : sp - amt};
    @(posedge clk_in);
    evt_out <= '0;
  endtask
  // Entry request carries the pointer from before the saved words
  task automatic frame(input logic [15:0] sp, input logic [15:0] ip, input logic [15:0] proc_status_word,
                       input logic [15:0] code_segment_pointer);
    @(posedge clk_in);
    entry_out <= {1'b1, sp, ip, proc_status_word, code_segment_pointer};
    @(posedge clk_in);
    entry_out <= '0;
  endtask
endmodule

// *** verif/sstk_map_check_monitor.sv ***
// Port-level checker for the stack window mapper and limit checker
`timescale 1ns/1ns
module sstk_monitor
  import sstk_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic ARST_N_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [17:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  input wire sstk_evt_t STACK_EVT_IN,
  input wire logic [15:0] ACC_SP_IN,
  input wire logic [15:0] PHYS_ADDR_OUT,
  input wire sstk_entry_t STACK_ENTRY_IN,
  input wire sstk_wr_t FRAME_WR_OUT,
  input wire logic FRAME_DONE_OUT,
  input wire logic [15:0] FRAME_SP_OUT,
  input wire logic FRAME_BUSY_OUT,
  input wire logic TRAP_OVF_OUT,
  input wire logic TRAP_UNF_OUT
);
  logic [15:0] lo_reg;
  logic [15:0] hi_reg;
  logic [1:0] sz_reg;
  logic wr_hit;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!ARST_N_IN);
  // Lane merge, then forced bits, so shadows match what software can hold
  function automatic logic [15:0] merge(input logic [15:0] old);
    logic [15:0] m;
    m = {WB_SEL_IN[1] ? WB_DAT_IN[15:8] : old[15:8], WB_SEL_IN[0] ? WB_DAT_IN[7:0] : old[7:0]};
    return (m & 16'h07fe) | 16'hf800;
  endfunction
  assign wr_hit = WB_CYC_IN && WB_STB_IN && WB_WE_IN && !WB_ACK_OUT;
  // Shadow settings, updated at the edge that takes the write
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      lo_reg <= 16'hfa00;
      hi_reg <= 16'hfc00;
      sz_reg <= 2'h0;
    end else if (wr_hit) begin
      if (WB_ADR_IN[17:2] == 16'hfe14) lo_reg <= merge(lo_reg);
      if (WB_ADR_IN[17:2] == 16'hfe16) hi_reg <= merge(hi_reg);
      if (WB_ADR_IN[17:2] == 16'hfe18 && WB_SEL_IN[0]) sz_reg <= WB_DAT_IN[1:0];
    end
  end
  a_lower_read: assert property (WB_ACK_OUT && !$past(WB_WE_IN) &&
    $past(WB_ADR_IN[17:2]) == 16'hfe14 |-> WB_DAT_OUT == {16'h0, lo_reg})
    else $error("lower limit read back wrong");
  a_upper_read: assert property (WB_ACK_OUT && !$past(WB_WE_IN) &&
    $past(WB_ADR_IN[17:2]) == 16'hfe16 |-> WB_DAT_OUT == {16'h0, hi_reg})
    else $error("upper limit read back wrong");
  // Start only out of reset, so the reset value of the view is never compared
  a_phys_map: assert property (ARST_N_IN |=> PHYS_ADDR_OUT ==
    16'hfbfe - (~$past(ACC_SP_IN) & 16'hfffe & (16'h01fe >> $past(sz_reg))))
    else $error("physical stack address wrong");
  a_ovf_raise: assert property ((STACK_EVT_IN.push || STACK_EVT_IN.sub) &&
    !FRAME_BUSY_OUT && STACK_EVT_IN.sp < lo_reg |-> ##2 TRAP_OVF_OUT)
    else $error("overflow trap missing");
  a_unf_raise: assert property ((STACK_EVT_IN.pop || STACK_EVT_IN.add) &&
    STACK_EVT_IN.sp > hi_reg |-> ##2 TRAP_UNF_OUT)
    else $error("underflow trap missing");
  a_unf_cause: assert property (TRAP_UNF_OUT |->
    $past(STACK_EVT_IN.pop || STACK_EVT_IN.add, 2))
    else $error("underflow trap without a pop or add");
  a_frame_words: assert property ($rose(FRAME_WR_OUT.we) |->
    FRAME_WR_OUT.we [*3] ##1 !FRAME_WR_OUT.we)
    else $error("frame did not write three words");
  a_frame_end: assert property (FRAME_DONE_OUT |-> FRAME_WR_OUT.we &&
    $past(STACK_ENTRY_IN.req, 4) && FRAME_SP_OUT == $past(STACK_ENTRY_IN.sp, 4) - 16'h0006)
    else $error("frame end pointer wrong");
endmodule
bind sstk_map_check sstk_monitor u_mon (.*);

// *** verif/test_system_stack_map_and_bounds_check.sv ***
// Self-checking bench for the stack window mapper and limit checker
`timescale 1ns/1ns
module test_system_stack_map_and_bounds_check
  import sstk_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [17:0] adr = 18'h0;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [15:0] acc = 16'hfc00;
  logic [15:0] phys;
  logic [15:0] fsp;
  sstk_evt_t evt;
  sstk_entry_t ent;
  sstk_wr_t fwr;
  logic fdone;
  logic fbusy;
  logic tovf;
  logic tunf;
  int err_total = 0;
  int n_checks = 0;
  int seed = 32'h6128755f;
  logic [31:0] q;
  logic [15:0] lo = 16'hfa00;
  logic [15:0] hi;
  logic [15:0] v;
  logic [15:0] sp0;
  logic [15:0] nsp;
  logic [15:0] amt;
  logic [1:0] k;
  logic [1:0] stk = 2'h0;
  // 100 MHz system clock
  always #5 clk = ~clk;
  sstk_map_check u_dut (.CLK_SYS_IN(clk), .ARST_N_IN(rst_n), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .STACK_EVT_IN(evt), .ACC_SP_IN(acc),
    .PHYS_ADDR_OUT(phys), .STACK_ENTRY_IN(ent), .FRAME_WR_OUT(fwr), .FRAME_DONE_OUT(fdone),
    .FRAME_SP_OUT(fsp), .FRAME_BUSY_OUT(fbusy), .TRAP_OVF_OUT(tovf), .TRAP_UNF_OUT(tunf));
  sstk_core_model u_core (.clk_in(clk), .evt_out(evt), .entry_out(ent));
  // Forced bits of a limit register
  function automatic logic [15:0] lim(input logic [15:0] x);
    return (x & 16'h07fe) | 16'hf800;
  endfunction
  // Window address: base minus masked inverted pointer
  function automatic logic [15:0] map(input logic [15:0] s, input logic [1:0] z);
    return 16'hfbfe - (~s & 16'hfffe & (16'h01fe >> z));
  endfunction
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Classic single cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [15:0] idx, input logic [15:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    sel <= s;
    wdat <= {16'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) err_total++;
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, 16'hfe16, 16'h0, 4'hf, q);
    chk("upper", q, 32'hfc00);
    // Random limits; the first lower write touches only the low byte
    for (int i = 0; i < 6; i++) begin
      v = 16'($random(seed));
      lo = lim((i == 0) ? {lo[15:8], v[7:0]} : v);
      wb(1'b0, 16'hfe14, 16'h0, 4'hf, q);
      if (i == 0) chk("lower", q, 32'hfa00);
      wb(1'b1, 16'hfe14, v, (i == 0) ? 4'h1 : 4'hf, q);
      wb(1'b0, 16'hfe14, 16'h0, 4'hf, q);
      chk("lower", q, {16'h0, lo});
      hi = lim(v ^ 16'h0155);
      wb(1'b1, 16'hfe16, v ^ 16'h0155, 4'hf, q);
      wb(1'b0, 16'hfe16, 16'h0, 4'hf, q);
      chk("upper", q, {16'h0, hi});
    end
    // Unmapped place acks, drops the write and reads zero
    wb(1'b1, 16'h0100, 16'hffff, 4'hf, q);
    wb(1'b0, 16'h0100, 16'h0, 4'hf, q);
    chk("unmapped", q, 32'h0);
    // Every size code with corners and random pointers
    for (int z = 0; z < 4; z++) begin
      wb(1'b1, 16'hfe18, 16'(z), 4'hf, q);
      for (int i = 0; i < 12; i++) begin
        v = (i == 0) ? 16'hfa00 : (i == 1) ? 16'hfc7e : 16'($random(seed)) | 16'hf800;
        @(posedge clk);
        acc <= v;
        @(posedge clk);
        #1 chk("phys", phys, map(v, 2'(z)));
        if (z == 0 && i == 0) chk("ident", phys, 32'hfa00);
      end
    end
    // Physical view register holds the last translation
    wb(1'b0, 16'hfe1c, 16'h0, 4'hf, q);
    chk("physview", q, {16'h0, map(v, 2'h3)});
    // Pointer events; the first four end on a limit or one word past it
    for (int i = 0; i < 40; i++) begin
      k = (i < 4) ? {1'b0, i[1]} : 2'($random(seed));
      amt = k[1] ? 16'($random(seed)) & 16'h000e : 16'h0002;
      sp0 = (i == 0) ? lo + 16'h2 : (i == 1) ? lo : (i == 2) ? hi - 16'h2 : hi;
      if (i >= 4) sp0 = lim(16'($random(seed)));
      nsp = k[0] ? sp0 + amt : sp0 - amt;
      stk = stk | {k[0] && nsp > hi, !k[0] && nsp < lo};
      u_core.step(k, sp0, amt);
      @(posedge clk);
      #1 chk("ovf", tovf, !k[0] && nsp < lo);
      chk("unf", tunf, k[0] && nsp > hi);
    end
    // Sticky trap record, then write one to clear it
    wb(1'b0, 16'hfe1a, 16'h0, 4'hf, q);
    chk("sticky", q, {30'h0, stk});
    wb(1'b1, 16'hfe1a, 16'h0003, 4'hf, q);
    wb(1'b0, 16'hfe1a, 16'h0, 4'hf, q);
    chk("sticky", q, 32'h0);
    // Cache use: limit twelve bytes above the lowest top of stack, so a
    // nested entry that trips it still fits its six words above that floor
    lo = lim(16'hfbe4 + 16'h000c);
    wb(1'b1, 16'hfe14, lo, 4'hf, q);
    // Nested entry: two frames of three words, size code 3 still set
    sp0 = 16'hfbf0;
    for (int f = 0; f < 2; f++) begin
      u_core.frame(sp0, 16'h1230 + 16'(f), 16'h4560, 16'h7890);
      for (int j = 1; j <= 3; j++) begin
        @(posedge clk);
        #1 chk("fwr", fwr, {1'b1, map(sp0 - 16'(2 * j), 2'h3),
          (j == 1) ? 16'h4560 : (j == 2) ? 16'h7890 : 16'h1230 + 16'(f)});
        chk("busy", fbusy, j < 3);
        if (j > 1) chk("fovf", tovf, sp0 - 16'(2 * j - 2) < lo);
      end
      chk("fend", {fdone, fsp}, {1'b1, sp0 - 16'h0006});
      sp0 = sp0 - 16'h0006;
    end
    wrap_up();
  end
  // Whole run needs about 400 cycles; this cuts a hang well after that
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end
endmodule

// *** verilog/sstk_defs.svh ***
// Constants for the stack window mapper and bounds checker
`ifndef SSTK_DEFS_SVH
`define SSTK_DEFS_SVH
// Register word indices; byte address is four times the index
`define SSTK_IDX_LOWER 16'hfe14
`define SSTK_IDX_UPPER 16'hfe16
`define SSTK_IDX_CONFIG 16'hfe18
`define SSTK_IDX_STATUS 16'hfe1a
`define SSTK_IDX_PHYS 16'hfe1c
// Reset values
`define SSTK_RST_LOWER 16'hfa00
`define SSTK_RST_UPPER 16'hfc00
`define SSTK_RST_SIZE 2'h0
// Limit register layout: bits 10..1 writable, 15..11 one, 0 zero
`define SSTK_LIM_MSB 10
`define SSTK_LIM_LSB 1
`define SSTK_LIM_ONES 5'h1f
`define SSTK_LIM_ZERO 1'h0
// Physical stack window
`define SSTK_PHYS_BASE 16'hfbfe
`define SSTK_MASK_256 16'h01fe
`define SSTK_MASK_128 16'h00fe
`define SSTK_MASK_64 16'h007e
`define SSTK_MASK_32 16'h003e
// Size select encodings
`define SSTK_SZ_256 2'h0
`define SSTK_SZ_128 2'h1
`define SSTK_SZ_64 2'h2
`define SSTK_SZ_32 2'h3
// One stack word in bytes
`define SSTK_WORD_BYTES 16'h0002
// Status bit positions
`define SSTK_ST_OVF 0
`define SSTK_ST_UNF 1
`endif

// *** verilog/sstk_map_check.sv ***
// Stack pointer to physical window mapper with limit checking
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "sstk_defs.svh"

module sstk_map_check
  import sstk_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic ARST_N_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [17:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire sstk_evt_t STACK_EVT_IN,
  input wire logic [15:0] ACC_SP_IN,
  output logic [15:0] PHYS_ADDR_OUT,
  input wire sstk_entry_t STACK_ENTRY_IN,
  output sstk_wr_t FRAME_WR_OUT,
  output logic FRAME_DONE_OUT,
  output logic [15:0] FRAME_SP_OUT,
  output logic FRAME_BUSY_OUT,
  output logic TRAP_OVF_OUT,
  output logic TRAP_UNF_OUT
);

  // Mask for the selected physical stack size
  function automatic logic [15:0] size_mask(input logic [1:0] sz);
    logic [15:0] m;
    m = `SSTK_MASK_256;
    case (sz)
      `SSTK_SZ_256: m = `SSTK_MASK_256;
      `SSTK_SZ_128: m = `SSTK_MASK_128;
      `SSTK_SZ_64: m = `SSTK_MASK_64;
      `SSTK_SZ_32: m = `SSTK_MASK_32;
      default: m = `SSTK_MASK_256;
    endcase
    return m;
  endfunction

  // Physical address; upper pointer bits are masked off, so every
  // virtual portion of the window size lands on the same area
  function automatic logic [15:0] phys_of(input logic [15:0] sp,
                                          input logic [1:0] sz);
    return `SSTK_PHYS_BASE - ((~sp) & size_mask(sz));
  endfunction

  // Limit register view: fixed ones above, fixed zero below
  function automatic logic [15:0] lim_view(input logic [9:0] v);
    return {`SSTK_LIM_ONES, v, `SSTK_LIM_ZERO};
  endfunction

  // Software state
  logic [9:0] lower_reg; // Writable bits of the lower limit
  logic [9:0] upper_reg; // Writable bits of the upper limit
  logic [1:0] size_reg; // Stack size select
  logic [1:0] sticky_reg; // Sticky overflow and underflow seen
  logic ack_reg;
  logic [31:0] rdata_reg;

  // Bus decode
  logic req;
  logic wr_lo;
  logic [15:0] idx;
  logic in_map;
  logic hit_lower;
  logic hit_upper;
  logic hit_config;
  logic hit_status;
  logic hit_phys;
  logic [15:0] lower_full;
  logic [15:0] upper_full;

  // Pointer check pipeline
  logic chk_push_reg;
  logic chk_pop_reg;
  logic [15:0] chk_sp_reg;
  logic ovf_reg;
  logic unf_reg;
  logic ovf_next;
  logic unf_next;

  // Frame push sequencer
  sstk_state_t state_reg;
  sstk_state_t state_next;
  logic [15:0] fsp_reg;
  logic [15:0] fip_reg;
  logic [15:0] fpsw_reg;
  logic [15:0] fcsp_reg;
  logic [15:0] fsp_dec;
  logic fpush;
  sstk_wr_t wr_reg;
  logic done_reg;
  logic [15:0] done_sp_reg;
  logic [15:0] phys_reg;

  assign lower_full = lim_view(lower_reg);
  assign upper_full = lim_view(upper_reg);

  // One access per cycle; the ack itself keeps a held request from
  // being taken twice
  assign req = WB_CYC_IN & WB_STB_IN & ~ack_reg;
  assign idx = WB_ADR_IN[17:2];
  assign hit_lower = (idx == `SSTK_IDX_LOWER);
  assign hit_upper = (idx == `SSTK_IDX_UPPER);
  assign hit_config = (idx == `SSTK_IDX_CONFIG);
  assign hit_status = (idx == `SSTK_IDX_STATUS);
  assign hit_phys = (idx == `SSTK_IDX_PHYS);
  assign in_map = hit_lower | hit_upper | hit_config | hit_status | hit_phys;
  // Only the low byte lanes carry register bits
  assign wr_lo = req & WB_WE_IN;

  // Acknowledge every access one cycle after it is taken
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  // Read data; unmapped words read as zero and still ack
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req && !WB_WE_IN) begin
      rdata_reg <= 32'h0000_0000;
      if (hit_lower) begin
        rdata_reg[15:0] <= lower_full;
      end
      if (hit_upper) begin
        rdata_reg[15:0] <= upper_full;
      end
      if (hit_config) begin
        rdata_reg[1:0] <= size_reg;
      end
      if (hit_status) begin
        rdata_reg[1:0] <= sticky_reg;
      end
      if (hit_phys) begin
        rdata_reg[15:0] <= phys_reg;
      end
      if (!in_map) begin
        rdata_reg <= 32'h0000_0000;
      end
    end
  end

  // Lower limit; only bits 10..1 take the written value
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      lower_reg <= 10'(`SSTK_RST_LOWER >> `SSTK_LIM_LSB);
    end else if (wr_lo && hit_lower) begin
      if (WB_SEL_IN[0]) begin
        lower_reg[6:0] <= WB_DAT_IN[7:1];
      end
      if (WB_SEL_IN[1]) begin
        lower_reg[9:7] <= WB_DAT_IN[10:8];
      end
    end
  end

  // Upper limit, same layout as the lower one
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      upper_reg <= 10'(`SSTK_RST_UPPER >> `SSTK_LIM_LSB);
    end else if (wr_lo && hit_upper) begin
      if (WB_SEL_IN[0]) begin
        upper_reg[6:0] <= WB_DAT_IN[7:1];
      end
      if (WB_SEL_IN[1]) begin
        upper_reg[9:7] <= WB_DAT_IN[10:8];
      end
    end
  end

  // Size select field of the system configuration
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      size_reg <= `SSTK_RST_SIZE;
    end else if (wr_lo && hit_config && WB_SEL_IN[0]) begin
      size_reg <= WB_DAT_IN[1:0];
    end
  end

  // Sticky trap record; writing one clears, a new trap wins
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sticky_reg <= 2'h0;
    end else begin
      if (wr_lo && hit_status && WB_SEL_IN[0]) begin
        sticky_reg <= sticky_reg & ~WB_DAT_IN[1:0];
      end
      if (ovf_next) begin
        sticky_reg[`SSTK_ST_OVF] <= 1'b1;
      end
      if (unf_next) begin
        sticky_reg[`SSTK_ST_UNF] <= 1'b1;
      end
    end
  end

  // Translate the core's access pointer; one cycle of latency
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      phys_reg <= 16'h0000;
    end else begin
      phys_reg <= phys_of(ACC_SP_IN, size_reg);
    end
  end

  // Capture the updated pointer; the compare runs next cycle so
  // the adder result is off the timing path of the comparators
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      chk_push_reg <= 1'b0;
      chk_pop_reg <= 1'b0;
      chk_sp_reg <= 16'h0000;
    end else begin
      chk_push_reg <= STACK_EVT_IN.push | STACK_EVT_IN.sub | fpush;
      chk_pop_reg <= STACK_EVT_IN.pop | STACK_EVT_IN.add;
      chk_sp_reg <= fpush ? fsp_dec : STACK_EVT_IN.sp;
    end
  end

  // Limit compares on the captured pointer
  always_comb begin
    ovf_next = chk_push_reg && (chk_sp_reg < lower_full);
    unf_next = chk_pop_reg && (chk_sp_reg > upper_full);
  end

  // Trap requests last exactly one cycle per detection
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf_next;
      unf_reg <= unf_next;
    end
  end

  // Next pointer of the frame: decrement before each word
  assign fsp_dec = fsp_reg - `SSTK_WORD_BYTES;
  assign fpush = (state_reg != SSTK_IDLE);

  // Frame sequencer: status word, segment, then instruction pointer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SSTK_IDLE: begin
        if (STACK_ENTRY_IN.req) begin
          state_next = SSTK_W0;
        end
      end
      SSTK_W0: state_next = SSTK_W1;
      SSTK_W1: state_next = SSTK_W2;
      SSTK_W2: state_next = SSTK_IDLE;
      default: state_next = SSTK_IDLE;
    endcase
  end

  // Sequencer state
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state_reg <= SSTK_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Entry words; requests during a frame are ignored, so a nested
  // entry must wait for the done pulse (six words for two frames)
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      fsp_reg <= 16'h0000;
      fip_reg <= 16'h0000;
      fpsw_reg <= 16'h0000;
      fcsp_reg <= 16'h0000;
    end else if (state_reg == SSTK_IDLE) begin
      if (STACK_ENTRY_IN.req) begin
        fsp_reg <= STACK_ENTRY_IN.sp;
        fip_reg <= STACK_ENTRY_IN.ip;
        fpsw_reg <= STACK_ENTRY_IN.proc_status_word;
        fcsp_reg <= STACK_ENTRY_IN.code_segment_pointer;
      end
    end else begin
      fsp_reg <= fsp_dec;
    end
  end

  // Stack writes toward internal RAM, one word per cycle
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wr_reg <= '0;
    end else begin
      wr_reg.we <= fpush;
      wr_reg.addr <= phys_of(fsp_dec, size_reg);
      case (state_reg)
        SSTK_W0: wr_reg.data <= fpsw_reg;
        SSTK_W1: wr_reg.data <= fcsp_reg;
        SSTK_W2: wr_reg.data <= fip_reg;
        default: wr_reg.data <= 16'h0000;
      endcase
    end
  end

  // Frame end: pulse with the pointer left after three words
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      done_reg <= 1'b0;
      done_sp_reg <= 16'h0000;
    end else begin
      done_reg <= (state_reg == SSTK_W2);
      if (state_reg == SSTK_W2) begin
        done_sp_reg <= fsp_dec;
      end
    end
  end

  // Outputs straight from flip-flops
  assign WB_ACK_OUT = ack_reg;
  assign WB_DAT_OUT = rdata_reg;
  assign PHYS_ADDR_OUT = phys_reg;
  assign FRAME_WR_OUT = wr_reg;
  assign FRAME_DONE_OUT = done_reg;
  assign FRAME_SP_OUT = done_sp_reg;
  assign TRAP_OVF_OUT = ovf_reg;
  assign TRAP_UNF_OUT = unf_reg;

  // Busy mirrors the sequencer state register
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      FRAME_BUSY_OUT <= 1'b0;
    end else begin
      FRAME_BUSY_OUT <= (state_next != SSTK_IDLE);
    end
  end

endmodule

// *** verilog/sstk_pkg.sv ***
// Types shared by the stack window mapper and its bench
package sstk_pkg;
  // Stack pointer update from the core, with its kind
  typedef struct packed {
    logic push;
    logic pop;
    logic sub;
    logic add;
    logic [15:0] sp;
  } sstk_evt_t;
  // Interrupt or trap entry request with the words to save
  typedef struct packed {
    logic req;
    logic [15:0] sp;
    logic [15:0] ip;
    logic [15:0] proc_status_word;
    logic [15:0] code_segment_pointer;
  } sstk_entry_t;
  // One stack write toward internal RAM
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] data;
  } sstk_wr_t;
  // Frame push sequencer states
  typedef enum logic [3:0] {
    SSTK_IDLE = 4'b0001,
    SSTK_W0 = 4'b0010,
    SSTK_W1 = 4'b0100,
    SSTK_W2 = 4'b1000
  } sstk_state_t;
endpackage
